// >>> rtl/acs_top.sv
// Conversion sequencer top: AXI4-Lite registers, triggers, SAR control, result path
`timescale 1ns/1ps
`default_nettype none
module acs_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_trigger_input,
  input wire logic alternate_clock,
  input wire logic async_conversion_clock,
  input wire logic stop_mode,
  input wire logic cmp_bit,
  output logic [4:0] channel_select,
  output logic dac_load,
  output logic [11:0] dac_value,
  output logic sample_enable,
  output logic analog_power,
  output logic low_power_config,
  output logic async_clock_enable,
  output acs_pkg::acs_pins_t upper_pins,
  output logic conversion_complete_irq
);
  logic [7:0] sc1;
  logic [7:0] sc2;
  logic [7:0] cfg;
  logic [7:0] cvh;
  logic [7:0] cvl;
  logic [7:0] pd_low;
  logic [7:0] pd_mid;
  logic [7:0] analog_pin_disable_upper;
  logic [7:0] res_h;
  logic [7:0] res_l;
  logic block_armed;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic abort;
  logic start_sw;
  logic trig_edge;
  logic [2:0] trig_sync;
  logic trig_seen;
  logic converter_clock_tick;
  logic alt_tick;
  logic async_tick;
  logic [2:0] alt_sync;
  logic [2:0] asy_sync;
  acs_pkg::acs_state_t state;
  logic [5:0] half_cnt;
  logic [3:0] bit_idx;
  logic [11:0] sar;
  logic [11:0] rounded;
  logic [12:0] cmp_diff;
  logic cmp_true;
  logic [11:0] cmp_value;
  logic [11:0] trial;
  logic blocked;
  logic ch_off;
  logic [1:0] mode;

  assign ch_off = (sc1[4:0] == acs_pkg::CH_OFF);
  assign mode = cfg[acs_pkg::CFG_MODE_LSB +: 2]; // R21
  assign channel_select = sc1[4:0];
  assign low_power_config = cfg[acs_pkg::CFG_LPC];
  assign upper_pins.ch_disable = analog_pin_disable_upper; // R1 R2
  assign conversion_complete_irq = sc1[acs_pkg::SC1_CONVERSION_COMPLETE_FLAG] & sc1[acs_pkg::SC1_IEN]; // R7
  assign analog_power = (state != acs_pkg::ACS_IDLE); // R4
  assign sample_enable = (state == acs_pkg::ACS_SAMPLE);
  assign async_clock_enable = (cfg[1:0] == acs_pkg::CLK_ASYNC) & ~ch_off; // R11

  // External clock pins sampled; edges become ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_sync <= 3'h0;
      asy_sync <= 3'h0;
      trig_sync <= 3'h0;
    end else if (ce) begin
      alt_sync <= {alt_sync[1:0], alternate_clock};
      asy_sync <= {asy_sync[1:0], async_conversion_clock};
      trig_sync <= {trig_sync[1:0], hw_trigger_input};
    end
  end
  assign alt_tick = alt_sync[1] & ~alt_sync[2];
  assign async_tick = asy_sync[1] & ~asy_sync[2];
  assign trig_edge = trig_sync[1] & ~trig_sync[2]; // R13

  acs_clkdiv u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .src_sel(cfg[acs_pkg::CFG_CLK_LSB +: 2]),
    .div_sel(cfg[acs_pkg::CFG_DIV_LSB +: 2]),
    .alt_tick(alt_tick),
    .async_tick(async_tick),
    .tick(converter_clock_tick)
  );

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= acs_pkg::ADDR_CTL) ?
          acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_lane;
  assign wr_lane = wr_fire & w_strb[0];
  assign start_sw = wr_lane & (aw_addr == acs_pkg::ADDR_SC1)
    & (w_data[4:0] != acs_pkg::CH_OFF) & ~sc2[acs_pkg::SC2_TRG]; // R16
  assign abort = (wr_lane & (aw_addr == acs_pkg::ADDR_SC1 || aw_addr == acs_pkg::ADDR_SC2
    || aw_addr == acs_pkg::ADDR_CFG || aw_addr == acs_pkg::ADDR_CVH
    || aw_addr == acs_pkg::ADDR_CVL))
    | (stop_mode & ~async_clock_enable); // R22

  // Read channel: one cycle answer
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= acs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= acs_pkg::RESP_OKAY;
        case (s_axi_araddr)
          acs_pkg::ADDR_SC1: s_axi_rdata <= {24'h0, sc1};
          acs_pkg::ADDR_SC2: s_axi_rdata <= {24'h0, sc2};
          acs_pkg::ADDR_RESH: s_axi_rdata <= {24'h0, res_h};
          acs_pkg::ADDR_RESL: s_axi_rdata <= {24'h0, res_l};
          acs_pkg::ADDR_CVH: s_axi_rdata <= {24'h0, cvh};
          acs_pkg::ADDR_CVL: s_axi_rdata <= {24'h0, cvl};
          acs_pkg::ADDR_CFG: s_axi_rdata <= {24'h0, cfg};
          acs_pkg::ADDR_PDL: s_axi_rdata <= {24'h0, pd_low};
          acs_pkg::ADDR_PDM: s_axi_rdata <= {24'h0, pd_mid};
          acs_pkg::ADDR_PDU: s_axi_rdata <= {24'h0, analog_pin_disable_upper};
          acs_pkg::ADDR_CTL: s_axi_rdata <= {28'h0, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= acs_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Block latch: high-byte read arms, low-byte read releases
  always_ff @(posedge clk) begin
    if (rst) begin
      block_armed <= 1'b0;
    end else if (ce && rd_fire) begin
      if (s_axi_araddr == acs_pkg::ADDR_RESH) begin
        block_armed <= 1'b1; // R25
      end else if (s_axi_araddr == acs_pkg::ADDR_RESL) begin
        block_armed <= 1'b0; // R25
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sc2 <= acs_pkg::REG_RESET;
      cfg <= acs_pkg::REG_RESET; // R9
      cvh <= acs_pkg::REG_RESET;
      cvl <= acs_pkg::REG_RESET;
      pd_low <= acs_pkg::REG_RESET;
      pd_mid <= acs_pkg::REG_RESET;
      analog_pin_disable_upper <= acs_pkg::REG_RESET;
    end else if (ce) begin
      sc2[acs_pkg::SC2_ACT] <= analog_power;
      if (wr_lane) begin
        case (aw_addr)
          acs_pkg::ADDR_SC2: sc2[6:0] <= w_data[6:0];
          acs_pkg::ADDR_CFG: cfg <= w_data[7:0];
          acs_pkg::ADDR_CVH: cvh <= {4'h0, w_data[3:0]};
          acs_pkg::ADDR_CVL: cvl <= w_data[7:0];
          acs_pkg::ADDR_PDL: pd_low <= w_data[7:0];
          acs_pkg::ADDR_PDM: pd_mid <= w_data[7:0];
          acs_pkg::ADDR_PDU: analog_pin_disable_upper <= w_data[7:0]; // R1
          default: ;
        endcase
      end
    end
  end

  // Hardware trigger gating
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_seen <= 1'b0;
    end else if (ce) begin
      if (abort | ~sc1[acs_pkg::SC1_CONT]) begin
        trig_seen <= 1'b0;
      end else if (trig_edge & sc2[acs_pkg::SC2_TRG] & state == acs_pkg::ACS_IDLE) begin
        trig_seen <= 1'b1; // R15
      end
    end
  end
  logic start_hw;
  assign start_hw = trig_edge & sc2[acs_pkg::SC2_TRG] & ~ch_off
    & (state == acs_pkg::ACS_IDLE) & ~trig_seen & ~abort; // R13 R14 R15

  // Rounding and compare
  always_comb begin
    trial = (sar | (12'(cmp_bit) << bit_idx)) | (12'h001 << (bit_idx - 4'h1)); // R5
    case (mode)
      acs_pkg::MODE_10: rounded = {2'h0, 10'((sar + 12'h002) >> 2)}; // R6
      acs_pkg::MODE_8: rounded = {4'h0, 8'((sar[8:0] + 9'h001) >> 1)}; // R6
      default: rounded = sar;
    endcase
    cmp_value = {cvh[3:0], cvl};
    cmp_diff = {1'b0, rounded} + {1'b0, ~cmp_value} + 13'h0001; // R23
    cmp_true = sc2[acs_pkg::SC2_CMPGT] ? cmp_diff[12] : ~cmp_diff[12]; // R23
  end
  assign blocked = block_armed & (mode != acs_pkg::MODE_8); // R18

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= acs_pkg::ACS_IDLE;
      half_cnt <= 6'h00;
      bit_idx <= 4'h0;
      sar <= 12'h000;
      dac_load <= 1'b0;
      dac_value <= 12'h000;
    end else if (ce) begin
      dac_load <= 1'b0;
      if (abort & ~start_sw) begin
        state <= acs_pkg::ACS_IDLE; // R22
      end else if (start_sw | start_hw) begin
        state <= acs_pkg::ACS_SAMPLE; // R16 R13
        half_cnt <= 6'h00;
      end else if (ch_off) begin
        state <= acs_pkg::ACS_IDLE; // R3
      end else begin
        case (state)
          acs_pkg::ACS_IDLE: ; // R4
          acs_pkg::ACS_SAMPLE: if (converter_clock_tick) begin
            half_cnt <= half_cnt + 6'h02;
            if (half_cnt + 6'h02 >= (cfg[acs_pkg::CFG_LSMP] ? acs_pkg::SAMPLE_LONG_HALVES
                : acs_pkg::SAMPLE_SHORT_HALVES)) begin // R24
              state <= acs_pkg::ACS_APPROX;
              bit_idx <= (mode == acs_pkg::MODE_8) ? acs_pkg::RAW_BITS_8 - 4'h1
                : acs_pkg::RAW_BITS - 4'h1; // R5
              sar <= 12'h000;
              // Trials left-aligned so the comparator sees one full scale
              dac_value <= 12'h800;
              dac_load <= 1'b1;
            end
          end
          acs_pkg::ACS_APPROX: if (converter_clock_tick) begin
            sar[bit_idx] <= cmp_bit; // R5
            if (bit_idx == 4'h0) begin
              state <= acs_pkg::ACS_DONE;
            end else begin
              bit_idx <= bit_idx - 4'h1;
              dac_value <= (mode == acs_pkg::MODE_8) ? (trial << 3) : trial;
              dac_load <= 1'b1;
            end
          end
          acs_pkg::ACS_DONE: begin
            if (sc2[acs_pkg::SC2_CMPE] & ~cmp_true & ~sc1[acs_pkg::SC1_CONT]) begin
              state <= acs_pkg::ACS_IDLE; // R19
            end else if (blocked | sc1[acs_pkg::SC1_CONT]
                | (sc2[acs_pkg::SC2_CMPE] & ~cmp_true)) begin
              state <= acs_pkg::ACS_SAMPLE; // R17 R19
              half_cnt <= 6'h00;
            end else begin
              state <= acs_pkg::ACS_IDLE;
            end
          end
          default: state <= acs_pkg::ACS_IDLE;
        endcase
      end
    end
  end

  // Result transfer and status control one
  logic xfer;
  assign xfer = (state == acs_pkg::ACS_DONE) & ~abort & ~ch_off & ~blocked
    & (~sc2[acs_pkg::SC2_CMPE] | cmp_true); // R8 R18 R23
  always_ff @(posedge clk) begin
    if (rst) begin
      sc1 <= acs_pkg::SC1_RESET;
      res_h <= acs_pkg::REG_RESET;
      res_l <= acs_pkg::REG_RESET;
    end else if (ce) begin
      if (wr_lane & (aw_addr == acs_pkg::ADDR_SC1)) begin
        sc1 <= {1'b0, w_data[6:0]};
      end else if (rd_fire & (s_axi_araddr == acs_pkg::ADDR_RESL)) begin
        sc1[acs_pkg::SC1_CONVERSION_COMPLETE_FLAG] <= 1'b0;
      end
      if (xfer) begin
        sc1[acs_pkg::SC1_CONVERSION_COMPLETE_FLAG] <= 1'b1; // R7
        if (sc2[acs_pkg::SC2_CMPE]) begin
          res_h <= {4'h0, cmp_diff[11:8]}; // R8
          res_l <= cmp_diff[7:0];
        end else begin
          res_h <= (mode == acs_pkg::MODE_8) ? res_h : {4'h0, rounded[11:8]}; // R6
          res_l <= rounded[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/acs_pkg.sv
// Package: register map, field layout, reset values and timing of the conversion sequencer
// Operation
// R1: Upper disable bit n governs channel 16+n
// R2: Disabled pin: hi-Z, no input, no pullup
// R3: Disabled in reset or channel all ones
// R4: Idle at lowest power between conversions
// R5: Raw value 12 bits, 9 in 8-bit mode
// R6: Round to 10 or 8 bits, store
// R7: Set flag; interrupt if enable high then
// R8: Compare enable checks every result
// R9: Four clock sources, bus clock after reset
// R10: Halved bus plus divider reaches 16
// R11: Async clock keeps running in wait, stop3
// R12: Divider ratios 1, 2, 4 or 8
// R13: Hardware trigger rising edge starts conversion
// R14: Trigger edge ignored while converting
// R15: Continuous hardware: only first edge counts
// R16: Software write, channel not ones, starts
// R17: Continuous restarts after each transfer
// R18: High read, low unread blocks transfer
// R19: Blocked transfer restarts, except compare miss single
// R20: Software avoids result reads during single
// R21: Mode 00 8-bit, 01 12-bit, 10 10-bit
// R22: Register writes, reset, stop abort conversion
// R23: Compare greater-equal or less; miss transfers nothing
// R24: Sample 3.5 or 23.5 converter cycles; the code samples for 4 or 24 whole converter cycles
// R25: High read arms block, low read clears
package acs_pkg;
  localparam logic [7:0] ADDR_SC1 = 8'h00;
  localparam logic [7:0] ADDR_SC2 = 8'h04;
  localparam logic [7:0] ADDR_RESH = 8'h08;
  localparam logic [7:0] ADDR_RESL = 8'h0C;
  localparam logic [7:0] ADDR_CVH = 8'h10;
  localparam logic [7:0] ADDR_CVL = 8'h14;
  localparam logic [7:0] ADDR_CFG = 8'h18;
  localparam logic [7:0] ADDR_PDL = 8'h1C;
  localparam logic [7:0] ADDR_PDM = 8'h20;
  localparam logic [7:0] ADDR_PDU = 8'h24;
  localparam logic [7:0] ADDR_CTL = 8'h28;
  // SC1 fields
  localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH_LSB = 0;
  localparam logic [4:0] CH_OFF = 5'h1F;
  // SC2 fields
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CMPE = 5;
  localparam int SC2_CMPGT = 4;
  // CFG fields
  localparam int CFG_LPC = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [7:0] SC1_RESET = 8'h1F;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Sample phase in half converter cycles: 3.5 and 23.5 cycles
  localparam logic [5:0] SAMPLE_SHORT_HALVES = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALVES = 6'h2F;
  localparam logic [3:0] RAW_BITS = 4'hC;
  localparam logic [3:0] RAW_BITS_8 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [7:0] ch_disable;
  } acs_pins_t;
  typedef enum logic [3:0] {
    ACS_IDLE = 4'h1,
    ACS_SAMPLE = 4'h2,
    ACS_APPROX = 4'h4,
    ACS_DONE = 4'h8
  } acs_state_t;
endpackage

// >>> rtl/acs_clkdiv.sv
// Converter clock tick generator: source select and divide
`timescale 1ns/1ps
`default_nettype none
module acs_clkdiv (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] div_sel,
  input wire logic alt_tick,
  input wire logic async_tick,
  output logic tick
);
  logic half;
  logic src_tick;
  logic [2:0] cnt;
  logic [2:0] limit;
  always_comb begin
    case (src_sel)
      acs_pkg::CLK_BUS: src_tick = 1'b1;
      acs_pkg::CLK_BUS2: src_tick = half;
      acs_pkg::CLK_ALT: src_tick = alt_tick;
      default: src_tick = async_tick;
    endcase
    limit = 3'((4'h1 << div_sel) - 4'h1); // R12
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      half <= 1'b0;
    end else if (ce) begin
      half <= ~half; // R10
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 3'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (src_tick) begin
        if (cnt >= limit) begin
          cnt <= 3'h0;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/acs_analog_model.sv
// Behavioural comparator that faces the trial value of the approximation engine
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
  input wire logic clk,
  input wire logic analog_power,
  input wire logic [11:0] dac_value,
  input wire logic [11:0] vin,
  output logic cmp_bit
);
  logic last = 1'b0;
  // Unpowered output means nothing, so show the inverse of the last level
  assign cmp_bit = analog_power ? (vin >= dac_value) : ~last;
  always_ff @(posedge clk) begin
    last <= cmp_bit;
  end
endmodule
`default_nettype wire

// >>> tb/acs_properties.sv
// Port-level assertions for the conversion sequencer top
`timescale 1ns/1ps
`default_nettype none
module acs_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic [4:0] channel_select,
  input wire logic dac_load,
  input wire logic sample_enable,
  input wire logic analog_power,
  input wire acs_pkg::acs_pins_t upper_pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> channel_select == acs_pkg::CH_OFF && !analog_power)
    else $error("sequencer not idle after reset");
  a_chan_off_idle: assert property (channel_select == acs_pkg::CH_OFF |-> !analog_power)
    else $error("converter powered with channel off");
  a_pins_on_write: assert property (!$past(rst) && $changed(upper_pins) |-> $rose(s_axi_bvalid))
    else $error("pin disable changed without a write");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_sample_min: assert property ($rose(sample_enable)
    |-> (sample_enable || stop_mode || s_axi_bvalid)[*4])
    else $error("sample phase too short");
  a_trial_powered: assert property (dac_load |-> !sample_enable && analog_power)
    else $error("trial value loaded outside approximation");
endmodule
bind acs_top acs_properties u_props (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .stop_mode, .channel_select, .dac_load, .sample_enable, .analog_power, .upper_pins);
`default_nettype wire

// >>> tb/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
  logic clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hw_trigger_input;
  logic alternate_clock, async_conversion_clock, stop_mode, cmp_bit, dac_load, sample_enable;
  logic analog_power, low_power_config, async_clock_enable, conversion_complete_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] channel_select, ch;
  logic [11:0] dac_value, vin;
  logic [15:0] e;
  acs_pkg::acs_pins_t upper_pins;
  int n_errors, n_tests, k;
  int seed = 32'h5CEC;

  acs_top u_dut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .hw_trigger_input, .alternate_clock, .async_conversion_clock, .stop_mode,
    .cmp_bit, .channel_select, .dac_load, .dac_value, .sample_enable, .analog_power,
    .low_power_config, .async_clock_enable, .upper_pins, .conversion_complete_irq);
  acs_analog_model u_ana (.clk, .analog_power, .dac_value, .vin, .cmp_bit);

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    alternate_clock <= ~alternate_clock;
    async_conversion_clock <= alternate_clock;
  end

  task automatic final_report;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bready and rready stay high, so every answer is taken when first offered
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (n >= 100) n_errors++;
    chk_resp(s_axi_bresp, acs_pkg::RESP_OKAY);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rr);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (n >= 100) n_errors++;
    x = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    axi_read(a, d, r);
    chk_resp(r, acs_pkg::RESP_OKAY);
    chk(d, x);
  endtask

  // Bounded wait; a missing completion shows as irq low
  task automatic wait_irq(input logic exp);
    k = 0;
    while (conversion_complete_irq !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, conversion_complete_irq}, {31'h0, exp});
  endtask

  task automatic pulse;
    hw_trigger_input <= 1'b1;
    repeat (3) @(posedge clk);
    hw_trigger_input <= 1'b0;
  endtask

  // Inputs keep their low four bits clear so rounding is exact
  function automatic logic [15:0] exp_res(input logic [1:0] m, input logic [11:0] x);
    case (m)
      2'h0: exp_res = {8'h00, x[11:4]};
      2'h1: exp_res = {4'h0, x};
      default: exp_res = {6'h00, x[11:2]};
    endcase
  endfunction

  initial begin
    #1000000;
    n_errors++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hw_trigger_input, stop_mode} = '0;
    {alternate_clock, async_conversion_clock, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    vin = 12'h000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(acs_pkg::ADDR_SC1, 32'h1F);
    rd_chk(acs_pkg::ADDR_CFG, 32'h0);
    rd_chk(acs_pkg::ADDR_PDU, 32'h0);
    chk({31'h0, analog_power}, 32'h0);
    axi_read(8'h30, d, r);
    chk_resp(r, acs_pkg::RESP_SLVERR);
    repeat (4) begin
      v = $random(seed);
      wr(acs_pkg::ADDR_PDU, v);
      rd_chk(acs_pkg::ADDR_PDU, {24'h0, v[7:0]});
      chk({24'h0, upper_pins}, {24'h0, v[7:0]});
    end
    ch = 5'($random(seed)) & 5'h0F;
    for (int m = 0; m < 3; m++) begin
      vin <= 12'($random(seed)) & 12'hFF0;
      wr(acs_pkg::ADDR_CFG, 32'(m) << acs_pkg::CFG_MODE_LSB);
      wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
      wait_irq(1'b1);
      e = exp_res(2'(m), vin);
      rd_chk(acs_pkg::ADDR_RESH, {24'h0, e[15:8]});
      rd_chk(acs_pkg::ADDR_RESL, {24'h0, e[7:0]});
      chk({31'h0, conversion_complete_irq}, 32'h0);
    end
    wr(acs_pkg::ADDR_SC1, 32'(ch));
    repeat (60) @(posedge clk);
    rd_chk(acs_pkg::ADDR_SC1, 32'h80 | 32'(ch));
    chk({31'h0, conversion_complete_irq}, 32'h0);
    wr(acs_pkg::ADDR_CFG, 32'h4);
    wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
    axi_read(acs_pkg::ADDR_RESH, d, r);
    wait_irq(1'b0);
    axi_read(acs_pkg::ADDR_RESL, d, r);
    wait_irq(1'b1);
    rd_chk(acs_pkg::ADDR_RESH, {28'h0, vin[11:8]});
    rd_chk(acs_pkg::ADDR_RESL, {24'h0, vin[7:0]});
    vin <= 12'h800;
    wr(acs_pkg::ADDR_CVH, 32'h7);
    wr(acs_pkg::ADDR_CVL, 32'h0);
    wr(acs_pkg::ADDR_SC2, 32'h30);
    wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
    wait_irq(1'b1);
    rd_chk(acs_pkg::ADDR_RESH, 32'h1);
    rd_chk(acs_pkg::ADDR_RESL, 32'h0);
    wr(acs_pkg::ADDR_CVH, 32'h9);
    wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
    wait_irq(1'b0);
    rd_chk(acs_pkg::ADDR_CTL, {28'h0, acs_pkg::ACS_IDLE});
    rd_chk(acs_pkg::ADDR_RESH, 32'h1);
    rd_chk(acs_pkg::ADDR_RESL, 32'h0);
    wr(acs_pkg::ADDR_SC2, 32'h20);
    wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
    wait_irq(1'b1);
    wr(acs_pkg::ADDR_CFG, 32'h83);
    chk({30'h0, low_power_config, async_clock_enable}, 32'h3);
    wr(acs_pkg::ADDR_SC2, 32'h40);
    wr(acs_pkg::ADDR_CFG, 32'h64);
    wr(acs_pkg::ADDR_SC1, 32'h40 | 32'(ch));
    repeat (20) @(posedge clk);
    rd_chk(acs_pkg::ADDR_CTL, {28'h0, acs_pkg::ACS_IDLE});
    pulse();
    repeat (20) @(posedge clk);
    pulse();
    repeat (60) @(posedge clk);
    chk({31'h0, conversion_complete_irq}, 32'h0);
    wait_irq(1'b1);
    rd_chk(acs_pkg::ADDR_RESL, 32'h0);
    wait_irq(1'b0);
    wr(acs_pkg::ADDR_SC2, 32'h0);
    wr(acs_pkg::ADDR_CFG, 32'h4);
    wr(acs_pkg::ADDR_SC1, 32'h60 | 32'(ch));
    wait_irq(1'b1);
    axi_read(acs_pkg::ADDR_RESL, d, r);
    wait_irq(1'b1);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(acs_pkg::ADDR_CTL, {28'h0, acs_pkg::ACS_IDLE});
    stop_mode <= 1'b0;
    axi_read(acs_pkg::ADDR_RESL, d, r);
    wait_irq(1'b0);
    wr(acs_pkg::ADDR_SC1, 32'h1F);
    chk({31'h0, analog_power}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
